// file: verilog/lpi_map.svh
// register offsets, field positions, reset values and timing counts for idle control
`ifndef LPI_MAP_SVH
`define LPI_MAP_SVH
`define LPI_ADDR_W          8
`define LPI_CSR_OFS         8'h30
`define LPI_TMR_OFS         8'h34
`define LPI_IRQ_OFS         8'h38
`define LPI_MSK_OFS         8'h3C
`define LPI_CTL_OFS         8'h40
`define LPI_CSR_TXA_BIT     19
`define LPI_CSR_LINK_EN_BIT 18
`define LPI_CSR_LINK_UP_BIT 17
`define LPI_CSR_EN_BIT      16
`define LPI_CSR_RXST_BIT    9
`define LPI_CSR_TXST_BIT    8
`define LPI_CSR_RXEX_BIT    3
`define LPI_CSR_RXEN_BIT    2
`define LPI_CSR_TXEX_BIT    1
`define LPI_CSR_TXEN_BIT    0
`define LPI_TMR_LINK_LSB    16
`define LPI_TMR_LINK_W      10
`define LPI_TMR_WAKE_W      16
`define LPI_LINK_MS_RESET   10'h3E8
`define LPI_WAKE_US_RESET   16'h0000
`define LPI_IRQ_BIT         10
`define LPI_CLK_MHZ         40
`define LPI_US_NS           1000
`define LPI_CLK_NS          25
`define LPI_US_CYCLES       (`LPI_US_NS / `LPI_CLK_NS)
`define LPI_MS_US           1000
`endif

// file: verilog/lpi_pkg.sv
// types for the low power idle control block
`default_nettype none
package lpi_pkg;
  typedef enum logic [1:0] {
    LPI_NORMAL = 2'b00,
    LPI_DRAIN  = 2'b01,
    LPI_IDLE   = 2'b11,
    LPI_WAKE   = 2'b10
  } lpi_tx_state_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } lpi_bus_t;
endpackage
`default_nettype wire

// file: verilog/lpi_tick_gen.sv
// microsecond and millisecond tick divider
`timescale 1ns/1ps
`default_nettype none
`include "lpi_map.svh"
module lpi_tick_gen
  import lpi_pkg::*;
#(
  parameter int US_CYCLES = `LPI_US_CYCLES,
  parameter int MS_US     = `LPI_MS_US
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  output logic      o_us_tick,
  output logic      o_ms_tick
);
  logic [15:0] us_cnt;
  logic [15:0] next_us_cnt;
  logic [15:0] ms_cnt;
  logic [15:0] next_ms_cnt;
  logic        next_us_tick;
  logic        next_ms_tick;
  // divider chain: clock cycles to microseconds to milliseconds
  always_comb begin
    next_us_cnt  = us_cnt + 16'h0001;
    next_ms_cnt  = ms_cnt;
    next_us_tick = 1'b0;
    next_ms_tick = 1'b0;
    if (us_cnt == 16'(US_CYCLES - 1)) begin
      next_us_cnt  = 16'h0000;
      next_us_tick = 1'b1;
      next_ms_cnt  = ms_cnt + 16'h0001;
      if (ms_cnt == 16'(MS_US - 1)) begin
        next_ms_cnt  = 16'h0000;
        next_ms_tick = 1'b1;
      end
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      us_cnt    <= 16'h0000;
      ms_cnt    <= 16'h0000;
      o_us_tick <= 1'b0;
      o_ms_tick <= 1'b0;
    end else begin
      us_cnt    <= next_us_cnt;
      ms_cnt    <= next_ms_cnt;
      o_us_tick <= next_us_tick;
      o_ms_tick <= next_ms_tick;
    end
  end
endmodule
`default_nettype wire

// file: verilog/lpi_rx_track.sv
// receive idle state tracker with entry and exit events
`timescale 1ns/1ps
`default_nettype none
module lpi_rx_track
  import lpi_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  input  wire logic i_rx_idle_pin,
  output logic      o_rx_idle_state,
  output logic      o_rx_enter,
  output logic      o_rx_exit
);
  logic sync1;
  logic sync2;
  logic next_state;
  logic next_enter;
  logic next_exit;
  // edge detection on the synchronised idle indication
  always_comb begin
    next_state = sync2;
    next_enter = sync2 & ~o_rx_idle_state;
    next_exit  = ~sync2 & o_rx_idle_state;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync1           <= 1'b0;
      sync2           <= 1'b0;
      o_rx_idle_state <= 1'b0;
      o_rx_enter      <= 1'b0;
      o_rx_exit       <= 1'b0;
    end else begin
      sync1           <= i_rx_idle_pin;
      sync2           <= sync1;
      o_rx_idle_state <= next_state;
      o_rx_enter      <= next_enter;
      o_rx_exit       <= next_exit;
    end
  end
endmodule
`default_nettype wire

// file: verilog/lpi_ctrl.sv
// low power idle control: registers, transmit idle sequencer, receive tracking
`timescale 1ns/1ps
`default_nettype none
`include "lpi_map.svh"
module lpi_ctrl
  import lpi_pkg::*;
#(
  parameter int US_CYCLES = `LPI_US_CYCLES,
  parameter int MS_US     = `LPI_MS_US
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_tx_pending,
  input  wire logic        i_tx_flush,
  input  wire logic        i_rx_idle_pin,
  output logic             o_tx_idle_pattern,
  output logic             o_tx_hold,
  output logic             o_irq
);
  //////////////////////////////////////////////////////////////////////////////
  lpi_bus_t      bus;
  logic          us_tick;
  logic          ms_tick;
  logic          rx_state;
  logic          rx_enter;
  logic          rx_exit;
  logic          txa;
  logic          phy_link_status_enable;
  logic          phy_link_up;
  logic          en;
  logic          rxex;
  logic          rxen;
  logic          txex;
  logic          txen;
  logic          irq_st;
  logic          irq_msk;
  logic [9:0]    link_up_timer_ms;
  logic [15:0]   wake_timer_us;
  logic [9:0]    link_cnt;
  logic [15:0]   wake_cnt;
  lpi_tx_state_t st;
  logic          next_txa;
  logic          next_phy_link_status_enable;
  logic          next_phy_link_up;
  logic          next_en;
  logic          next_rxex;
  logic          next_rxen;
  logic          next_txex;
  logic          next_txen;
  logic          next_irq_st;
  logic          next_irq_msk;
  logic [9:0]    next_link_up_timer_ms;
  logic [15:0]   next_wake_timer_us;
  logic [9:0]    next_link_cnt;
  logic [15:0]   next_wake_cnt;
  lpi_tx_state_t next_st;
  logic [31:0]   next_rdata;
  logic          link_ok;
  logic          tx_enter_ev;
  logic          tx_exit_ev;
  logic          csr_rd;
  logic          next_tx_pattern;
  logic          next_tx_hold;
  logic          next_irq;

  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // register hit test shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // tick divider and receive tracker
  lpi_tick_gen #(.US_CYCLES(US_CYCLES), .MS_US(MS_US)) u_tick (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .o_us_tick  (us_tick),
    .o_ms_tick  (ms_tick)
  );
  lpi_rx_track u_rx (
    .i_core_clk      (i_core_clk),
    .i_reset         (i_reset),
    .i_rx_idle_pin   (i_rx_idle_pin),
    .o_rx_idle_state (rx_state),
    .o_rx_enter      (rx_enter),
    .o_rx_exit       (rx_exit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // link timer, transmit sequencer and registers
  always_comb begin
    csr_rd        = bus.rd & hit(bus.addr, `LPI_CSR_OFS);
    link_ok       = (link_cnt >= link_up_timer_ms);
    next_link_cnt = link_cnt;
    if (!phy_link_up) begin
      next_link_cnt = 10'h000;
    end else if (ms_tick && !link_ok) begin
      next_link_cnt = link_cnt + 10'h001;
    end
    next_st       = st;
    next_wake_cnt = wake_cnt;
    tx_enter_ev   = 1'b0;
    tx_exit_ev    = 1'b0;
    next_en       = en;
    unique case (st)
      LPI_NORMAL: begin
        if (en && link_ok) begin
          next_st = LPI_DRAIN;
        end
      end
      LPI_DRAIN: begin
        if (!en || !link_ok) begin
          next_st = LPI_NORMAL;
        end else if (!txa || (!i_tx_pending && !i_tx_flush)) begin
          next_st     = LPI_IDLE;
          tx_enter_ev = 1'b1;
        end
      end
      LPI_IDLE: begin
        if ((!txa && !en) || (txa && (i_tx_pending || i_tx_flush || !en))) begin
          next_st       = LPI_WAKE;
          next_wake_cnt = 16'h0000;
          if (txa) begin
            next_en = 1'b0;
          end
        end
      end
      LPI_WAKE: begin
        if (wake_cnt >= wake_timer_us) begin
          next_st    = LPI_NORMAL;
          tx_exit_ev = 1'b1;
        end else if (us_tick) begin
          next_wake_cnt = wake_cnt + 16'h0001;
        end
      end
    endcase
    next_txa     = txa;
    next_phy_link_status_enable = phy_link_status_enable;
    next_phy_link_up            = phy_link_up;
    next_link_up_timer_ms       = link_up_timer_ms;
    next_wake_timer_us          = wake_timer_us;
    next_irq_msk                = irq_msk;
    if (bus.wr && hit(bus.addr, `LPI_CSR_OFS)) begin
      next_txa                    = bus.wdata[`LPI_CSR_TXA_BIT];
      next_phy_link_status_enable = bus.wdata[`LPI_CSR_LINK_EN_BIT];
      next_phy_link_up            = bus.wdata[`LPI_CSR_LINK_UP_BIT];
      if (!(st == LPI_IDLE && next_st == LPI_WAKE && txa)) begin
        next_en = bus.wdata[`LPI_CSR_EN_BIT];
      end
    end
    if (bus.wr && hit(bus.addr, `LPI_TMR_OFS)) begin
      next_link_up_timer_ms = bus.wdata[`LPI_TMR_LINK_LSB +: `LPI_TMR_LINK_W];
      next_wake_timer_us    = bus.wdata[`LPI_TMR_WAKE_W-1:0];
    end
    if (bus.wr && hit(bus.addr, `LPI_MSK_OFS)) begin
      next_irq_msk = bus.wdata[`LPI_IRQ_BIT];
    end
    // sticky flags: a new event wins over the read clear
    next_rxex   = (rxex & ~csr_rd) | rx_exit;
    next_rxen   = (rxen & ~csr_rd) | rx_enter;
    next_txex   = (txex & ~csr_rd) | tx_exit_ev;
    next_txen   = (txen & ~csr_rd) | tx_enter_ev;
    next_irq_st = (irq_st & ~csr_rd) | rx_exit | rx_enter | tx_exit_ev | tx_enter_ev;
    // output registers follow the next state
    next_tx_pattern = (next_st == LPI_IDLE);
    next_tx_hold    = (next_st == LPI_IDLE) || (next_st == LPI_WAKE);
    next_irq        = next_irq_st & ~next_irq_msk;
    next_rdata  = 32'h0000_0000;
    if (bus.rd) begin
      if (hit(bus.addr, `LPI_CSR_OFS)) begin
        next_rdata[`LPI_CSR_TXA_BIT]   = txa;
        next_rdata[`LPI_CSR_LINK_EN_BIT] = phy_link_status_enable;
        next_rdata[`LPI_CSR_LINK_UP_BIT] = phy_link_up;
        next_rdata[`LPI_CSR_EN_BIT]    = en;
        next_rdata[`LPI_CSR_RXST_BIT]  = rx_state;
        next_rdata[`LPI_CSR_TXST_BIT]  = (st == LPI_IDLE);
        next_rdata[`LPI_CSR_RXEX_BIT]  = rxex;
        next_rdata[`LPI_CSR_RXEN_BIT]  = rxen;
        next_rdata[`LPI_CSR_TXEX_BIT]  = txex;
        next_rdata[`LPI_CSR_TXEN_BIT]  = txen;
      end else if (hit(bus.addr, `LPI_TMR_OFS)) begin
        next_rdata[`LPI_TMR_LINK_LSB +: `LPI_TMR_LINK_W] = link_up_timer_ms;
        next_rdata[`LPI_TMR_WAKE_W-1:0] = wake_timer_us;
      end else if (hit(bus.addr, `LPI_IRQ_OFS)) begin
        next_rdata[`LPI_IRQ_BIT] = irq_st;
      end else if (hit(bus.addr, `LPI_MSK_OFS)) begin
        next_rdata[`LPI_IRQ_BIT] = irq_msk;
      end
    end
  end

  // state registers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st                <= LPI_NORMAL;
      txa               <= 1'b0;
      phy_link_status_enable <= 1'b0;
      phy_link_up       <= 1'b0;
      en                <= 1'b0;
      rxex              <= 1'b0;
      rxen              <= 1'b0;
      txex              <= 1'b0;
      txen              <= 1'b0;
      irq_st            <= 1'b0;
      irq_msk           <= 1'b0;
      link_up_timer_ms  <= `LPI_LINK_MS_RESET;
      wake_timer_us     <= `LPI_WAKE_US_RESET;
      link_cnt          <= 10'h000;
      wake_cnt          <= 16'h0000;
      o_rdata           <= 32'h0000_0000;
      o_tx_idle_pattern <= 1'b0;
      o_tx_hold         <= 1'b0;
      o_irq             <= 1'b0;
    end else begin
      st                <= next_st;
      txa               <= next_txa;
      phy_link_status_enable <= next_phy_link_status_enable;
      phy_link_up       <= next_phy_link_up;
      en                <= next_en;
      rxex              <= next_rxex;
      rxen              <= next_rxen;
      txex              <= next_txex;
      txen              <= next_txen;
      irq_st            <= next_irq_st;
      irq_msk           <= next_irq_msk;
      link_up_timer_ms  <= next_link_up_timer_ms;
      wake_timer_us     <= next_wake_timer_us;
      link_cnt          <= next_link_cnt;
      wake_cnt          <= next_wake_cnt;
      o_rdata           <= next_rdata;
      o_tx_idle_pattern <= next_tx_pattern;
      o_tx_hold         <= next_tx_hold;
      o_irq             <= next_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  idle_needs_link_a: assert property ($rose(o_tx_idle_pattern) |-> $past(link_ok))
    else $error("idle path without link time");
  auto_drain_a: assert property (st == LPI_DRAIN && txa && i_tx_pending |=> st != LPI_IDLE)
    else $error("idle entered with frames pending");
  auto_wake_a: assert property (st == LPI_IDLE && txa && i_tx_pending |=> st == LPI_WAKE && !en)
    else $error("automate exit or enable clear missing");
  manual_follow_a: assert property (st == LPI_IDLE && !txa && en && !(i_wr && i_addr == `LPI_CSR_OFS)
                                    |=> st == LPI_IDLE)
    else $error("manual idle left while enabled");
  tx_entry_flag_a: assert property (st == LPI_DRAIN ##1 st == LPI_IDLE |-> txen)
    else $error("entry flag not set");
  tx_exit_flag_a: assert property (st == LPI_WAKE ##1 st == LPI_NORMAL |-> txex && irq_st)
    else $error("exit flag not set after wake");
  read_clear_a: assert property (csr_rd && !rx_exit && !rx_enter && !tx_exit_ev && !tx_enter_ev
                                 |=> !rxex && !rxen && !txex && !txen && !irq_st)
    else $error("read did not clear flags");
  rx_entry_flag_a: assert property ($rose(rx_state) |=> rxen)
    else $error("receive entry flag missing");
  irq_mask_a: assert property (irq_msk |-> !o_irq)
    else $error("masked interrupt asserted");
  link_reset_a: assert property (!phy_link_up |=> link_cnt == 10'h000)
    else $error("link timer not restarted");
  link_count_a: assert property (phy_link_up && ms_tick && !link_ok |=> link_cnt == $past(link_cnt) + 10'h001)
    else $error("link timer missed a millisecond");
  manual_exit_a: assert property (st == LPI_IDLE && !txa && !en |=> st == LPI_WAKE)
    else $error("idle kept after enable cleared");
  flush_wake_a: assert property (st == LPI_IDLE && txa && i_tx_flush |=> st == LPI_WAKE && !en)
    else $error("flush did not wake the transmitter");
  wake_hold_a: assert property (st == LPI_WAKE && wake_cnt < wake_timer_us |=> st == LPI_WAKE)
    else $error("wake time cut short");
  enter_idle_c: cover property (st == LPI_DRAIN ##1 st == LPI_IDLE);
  auto_exit_c: cover property (st == LPI_IDLE && txa ##1 st == LPI_WAKE);
  wake_done_c: cover property (st == LPI_WAKE ##1 st == LPI_NORMAL);
  rx_cycle_c: cover property (rx_enter ##[1:20] rx_exit);
endmodule
`default_nettype wire

// file: sim/lpi_phy_model.sv
// phy side partner: sends idle pattern on request, counts transmit idle entries
`timescale 1ns/1ps
`default_nettype none
module lpi_phy_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_lpi_req,
  input  wire logic       i_tx_idle_pattern,
  output logic            o_rx_idle_pin,
  output logic      [7:0] o_tx_entries
);
  logic prev_tx;
  int   lag;
  initial begin
    o_rx_idle_pin = 1'b0;
    o_tx_entries  = 8'h00;
    prev_tx       = 1'b0;
    lag           = 0;
  end
  // follow the request after a random lag, count idle pattern starts
  always @(posedge i_core_clk) begin
    if (o_rx_idle_pin != i_lpi_req) begin
      if (lag == 0) begin
        o_rx_idle_pin <= i_lpi_req;
        lag = $urandom_range(2, 0);
      end else begin
        lag = lag - 1;
      end
    end
    prev_tx <= i_tx_idle_pattern;
    if (i_tx_idle_pattern && !prev_tx) begin
      o_tx_entries <= o_tx_entries + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_eee_low_power_idle_control.sv
// self-checking bench for the low power idle control block
`timescale 1ns/1ps
`default_nettype none
`include "lpi_map.svh"
module test_eee_low_power_idle_control;
  import lpi_pkg::*;
  localparam int          US  = 4;
  localparam int          MSU = 3;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        i_core_clk;
  logic        i_reset;
  logic        i_wr;
  logic        i_rd;
  logic        i_tx_pending;
  logic        i_tx_flush;
  logic        lpi_req;
  logic        rx_pin;
  logic        o_tx_idle_pattern;
  logic        o_tx_hold;
  logic        o_irq;
  logic [7:0]  i_addr;
  logic [7:0]  tx_entries;
  logic [31:0] i_wdata;
  logic [31:0] o_rdata;
  logic [31:0] rd_v;
  logic [31:0] seed_v;
  int          err_total;
  int          cmp_count;
  int          n;
  int          wake_us;

  lpi_ctrl #(.US_CYCLES(US), .MS_US(MSU)) i_dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_pending(i_tx_pending),
    .i_tx_flush(i_tx_flush), .i_rx_idle_pin(rx_pin), .o_tx_idle_pattern(o_tx_idle_pattern),
    .o_tx_hold(o_tx_hold), .o_irq(o_irq)
  );
  lpi_phy_model i_phy (
    .i_core_clk(i_core_clk), .i_lpi_req(lpi_req), .i_tx_idle_pattern(o_tx_idle_pattern),
    .o_rx_idle_pin(rx_pin), .o_tx_entries(tx_entries)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and helpers
  initial i_core_clk = 1'b0;
  always #12.5 i_core_clk = ~i_core_clk;

  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("[ERR] %0t got %h want %h mask %h", $time, got, exp, m);
    end
  endtask
  // expected control/status word
  function automatic logic [31:0] csr(input logic txa, up, en, rxs, txs, input logic [3:0] fl);
    csr = {12'h000, txa, 1'b0, up, en, 6'h00, rxs, txs, 4'h0, fl};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 rd_v = o_rdata;
    chk(rd_v, e, m);
    @(posedge i_core_clk);
  endtask
  // bounded wait for the idle pattern output to reach a level
  task automatic wait_tx(input logic v, input int lim);
    n = 0;
    #1;
    while (o_tx_idle_pattern !== v && n < lim) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    chk({31'h0, o_tx_idle_pattern}, {31'h0, v}, 32'h1);
    @(posedge i_core_clk);
  endtask
  // cycles until transmit hold drops
  task automatic hold_len();
    n = 0;
    #1;
    while (o_tx_hold === 1'b1 && n < 300) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    chk({31'h0, o_tx_hold}, 32'h0, 32'h1);
    @(posedge i_core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_reset, i_wr, i_rd, i_tx_pending, i_tx_flush, lpi_req} = 6'h20;
    i_addr    = 8'h00;
    i_wdata   = 32'h0;
    err_total = 0;
    cmp_count = 0;
    seed_v    = $urandom(32'h1B9E);
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    rdc(8'h30, 32'h0, ALL);
    rdc(8'h34, {6'h00, `LPI_LINK_MS_RESET, `LPI_WAKE_US_RESET}, ALL);
    wr(8'h40, ALL);
    rdc(8'h40, 32'h0, ALL);
    wake_us = $urandom_range(4, 2);
    wr(8'h34, {6'h00, 10'h002, 16'(wake_us)});
    rdc(8'h34, {6'h00, 10'h002, 16'(wake_us)}, ALL);
    // link down keeps the transmitter out of idle
    wr(8'h30, csr(0, 0, 1, 0, 0, 4'h0));
    repeat (60) @(posedge i_core_clk);
    wait_tx(1'b0, 0);
    // manual entry only after the link time
    wr(8'h30, csr(0, 1, 1, 0, 0, 4'h0));
    repeat (10) @(posedge i_core_clk);
    wait_tx(1'b0, 0);
    wait_tx(1'b1, 60);
    repeat (2) @(posedge i_core_clk);
    chk({31'h0, o_irq}, 32'h1, 32'h1);
    rdc(8'h30, csr(0, 1, 1, 0, 1, 4'h1), ALL);
    repeat (2) @(posedge i_core_clk);
    chk({31'h0, o_irq}, 32'h0, 32'h1);
    // manual exit waits the wake time
    wr(8'h30, csr(0, 1, 0, 0, 0, 4'h0));
    wait_tx(1'b0, 0);
    hold_len();
    chk({31'h0, n >= (wake_us - 1) * US && n <= wake_us * US + 1}, 32'h1, 32'h1);
    rdc(8'h30, csr(0, 1, 0, 0, 0, 4'h2), ALL);
    // receive side with the interrupt masked, then unmasked
    wr(8'h3C, 32'h400);
    rdc(8'h3C, 32'h400, ALL);
    lpi_req <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    rdc(8'h30, csr(0, 1, 0, 1, 0, 4'h4), ALL);
    rdc(8'h30, csr(0, 1, 0, 1, 0, 4'h0), ALL);
    lpi_req <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    chk({31'h0, o_irq}, 32'h0, 32'h1);
    rdc(8'h38, 32'h400, 32'h400);
    wr(8'h3C, 32'h0);
    repeat (2) @(posedge i_core_clk);
    chk({31'h0, o_irq}, 32'h1, 32'h1);
    rdc(8'h30, csr(0, 1, 0, 0, 0, 4'h8), ALL);
    lpi_req <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    lpi_req <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    rdc(8'h30, csr(0, 1, 0, 0, 0, 4'hC), ALL);
    rdc(8'h38, 32'h0, 32'h400);
    // automate mode: pending frame then fifo flush wake the transmitter
    for (int c = 0; c < 2; c++) begin
      i_tx_pending <= 1'b1;
      wr(8'h30, csr(1, 1, 1, 0, 0, 4'h0));
      repeat (20) @(posedge i_core_clk);
      wait_tx(1'b0, 0);
      i_tx_pending <= 1'b0;
      wait_tx(1'b1, 10);
      repeat ($urandom_range(9, 1)) @(posedge i_core_clk);
      if (c == 0) begin
        i_tx_pending <= 1'b1;
      end else begin
        i_tx_flush <= 1'b1;
      end
      wait_tx(1'b0, 4);
      i_tx_pending <= 1'b0;
      i_tx_flush   <= 1'b0;
      hold_len();
      rdc(8'h30, csr(1, 1, 0, 0, 0, 4'h0), 32'h10100);
    end
    repeat (5) @(posedge i_core_clk);
    chk({24'h0, tx_entries}, 32'h3, 32'hFF);
    test_done();
  end
endmodule
`default_nettype wire
